// ===== rt_timer.sv
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - One-shot counts to terminal value, then stops.
// - Continuous counts to terminal value, reloads and repeats.
// - Counter mode advances once per qualifying input edge.
// - Capture mode snapshots the count on a qualifying rising input edge.
// - Compare mode toggles the output pin at terminal count.
// - Gated mode counts only while the input is asserted.
// - Capture/compare counts while asserted, captures on deassert.
// - Count clock is source divided by prescaler, 1 to 4096.
// - The count register reads the live count at any time.
// - A period ends on the count clock after the end condition.
// - Each period end sets the flag; enabled flags raise IRQ.
// - Period end reloads 1 except in one-shot; reset clears count to 0.
// - In 32-bit operation the lower half controls govern everything.
// - In single 16-bit operation upper half controls are ignored.
// - Dual 16-bit splits values into bits 15:0 and 31:16.
// - Dual halves have their own source select and prescaler.
// - Pin events are latched on the next count clock edge.
// - Clearing enable reads back zero at once; the clock gate bit reads zero once the timer stopped.
// - Clock gate on, ready reads one once the source runs.
// - Clock gate readback reads one once the timer really runs.
// - Mode codes 0-8 and 14; the rest are reserved.
module rt_timer (
    input logic CLOCK,
    input logic RST,
    input rt_pkg::rt_bus_t BUS,
    output logic [31:0] RDATA,
    input logic [3:0] SRC_RDY,
    input logic [3:0] SRC_TICK,
    input logic [1:0] PIN_IN,
    output logic [1:0] PIN_OUT,
    output logic IRQ
);
    // ------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------
    function automatic logic [31:0] view(input logic [31:0] v,
            input int h, input logic casc);
        if (casc) return v;
        return {{rt_pkg::HALF_W{1'b0}},
            v[h*rt_pkg::HALF_W +: rt_pkg::HALF_W]};
    endfunction : view

    function automatic logic [rt_pkg::PRE_W-1:0] pres_lim(
            input logic [3:0] p);
        logic [3:0] q;
        q = (p > rt_pkg::PRES_MAX) ? rt_pkg::PRES_MAX : p;
        return rt_pkg::PRE_W'((13'h0001 << q) - 13'h0001);
    endfunction : pres_lim

    function automatic logic [15:0] ctrl0_word(
            input rt_pkg::rt_cfg_t c, input logic run);
        logic [15:0] w;
        w = '0;
        w[rt_pkg::MODE_LSB +: 4] = c.mode;
        w[rt_pkg::PRES_LSB +: 4] = c.pres;
        w[rt_pkg::POL_BIT] = c.pol;
        w[rt_pkg::EN_BIT] = c.en;
        w[rt_pkg::CLKEN_BIT] = run;
        w[rt_pkg::IE_BIT] = c.ie;
        return w;
    endfunction : ctrl0_word

    rt_pkg::rt_cfg_t cfg_q [2];
    rt_pkg::rt_width_t wid_q;
    logic [1:0] sel_q [2];
    logic [rt_pkg::PRE_W-1:0] pre_q [2];
    logic [31:0] cnt_q, cnt_d, cmp_q, pwm_q, rd_d, rdata_q;
    logic [1:0] irq_q, rdy_q, run_q, lat_q, lat_prev_q, out_q;
    logic [1:0] act, tick, adv, endp, cap;
    logic irq_out_q, casc;
    logic wr_cnt, wr_cmp, wr_pwm, wr_c0, wr_c1, wr_fl;

    assign wr_cnt = BUS.wr && BUS.addr == rt_pkg::CNT_OFS;
    assign wr_cmp = BUS.wr && BUS.addr == rt_pkg::CMP_OFS;
    assign wr_pwm = BUS.wr && BUS.addr == rt_pkg::PWM_OFS;
    assign wr_c0 = BUS.wr && BUS.addr == rt_pkg::CTRL0_OFS;
    assign wr_c1 = BUS.wr && BUS.addr == rt_pkg::CTRL1_OFS;
    assign wr_fl = BUS.wr && BUS.addr == rt_pkg::INTFL_OFS;
    assign casc = wid_q == rt_pkg::W_CASCADE;
    assign act = {wid_q == rt_pkg::W_DUAL, 1'b1};

    // ------------------------------------------------------------
    // Configuration registers.
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cfg_q[0] <= '0;
            cfg_q[1] <= '0;
            wid_q <= rt_pkg::W_CASCADE;
        end else begin
            for (int h = 0; h < 2; h++) begin
                if (endp[h] && cfg_q[h].mode == rt_pkg::M_ONESHOT) begin
                    cfg_q[h].en <= 1'b0;
                end
                if (wr_c0) begin
                    cfg_q[h].mode <= rt_pkg::rt_mode_t'(BUS.wdata[
                        h*rt_pkg::HALF_W + rt_pkg::MODE_LSB +: 4]);
                    cfg_q[h].pres <= BUS.wdata[
                        h*rt_pkg::HALF_W + rt_pkg::PRES_LSB +: 4];
                    cfg_q[h].pol <= BUS.wdata[
                        h*rt_pkg::HALF_W + rt_pkg::POL_BIT];
                    cfg_q[h].en <= BUS.wdata[
                        h*rt_pkg::HALF_W + rt_pkg::EN_BIT];
                    cfg_q[h].clken <= BUS.wdata[
                        h*rt_pkg::HALF_W + rt_pkg::CLKEN_BIT];
                    cfg_q[h].ie <= BUS.wdata[
                        h*rt_pkg::HALF_W + rt_pkg::IE_BIT];
                end
                if (wr_c1) begin
                    cfg_q[h].sel <= BUS.wdata[
                        h*rt_pkg::HALF_W + rt_pkg::SEL_LSB +: 2];
                end
            end
            if (wr_c1) begin
                wid_q <= rt_pkg::rt_width_t'(
                    BUS.wdata[rt_pkg::WID_LSB +: 2]);
            end
        end
    end

    // ------------------------------------------------------------
    // Clock source, gate and prescaler.
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            sel_q[0] <= '0;
            sel_q[1] <= '0;
            rdy_q <= '0;
            run_q <= '0;
        end else begin
            for (int h = 0; h < 2; h++) begin
                if (!cfg_q[h].clken && !rdy_q[h]) begin
                    sel_q[h] <= cfg_q[h].sel;
                end
                rdy_q[h] <= cfg_q[h].clken && SRC_RDY[sel_q[h]];
                run_q[h] <= cfg_q[h].en && rdy_q[h];
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pre_q[0] <= '0;
            pre_q[1] <= '0;
        end else begin
            for (int h = 0; h < 2; h++) begin
                if (!run_q[h]) begin
                    pre_q[h] <= '0;
                end else if (SRC_TICK[sel_q[h]]) begin
                    if (pre_q[h] == pres_lim(cfg_q[h].pres)) begin
                        pre_q[h] <= '0;
                    end else begin
                        pre_q[h] <= pre_q[h] + 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Input latching and mode events.
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            lat_q <= '0;
            lat_prev_q <= '0;
        end else begin
            for (int h = 0; h < 2; h++) begin
                if (tick[h]) begin
                    lat_q[h] <= PIN_IN[h];
                    lat_prev_q[h] <= lat_q[h];
                end
            end
        end
    end

    always_comb begin
        logic as, ap, rise, fall;
        as = 1'b0;
        ap = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        for (int h = 0; h < 2; h++) begin
            as = lat_q[h] ^ cfg_q[h].pol;
            ap = lat_prev_q[h] ^ cfg_q[h].pol;
            rise = as && !ap;
            fall = !as && ap;
            // cascade runs from the lower select
            tick[h] = act[h] && run_q[h] && SRC_TICK[sel_q[h]]
                && pre_q[h] == pres_lim(cfg_q[h].pres);
            cap[h] = 1'b0;
            case (cfg_q[h].mode)
                rt_pkg::M_ONESHOT, rt_pkg::M_CONT, rt_pkg::M_PWM,
                rt_pkg::M_COMPARE: begin
                    adv[h] = tick[h];
                end
                rt_pkg::M_COUNTER: begin
                    adv[h] = tick[h] && rise;
                end
                rt_pkg::M_CAPTURE: begin
                    adv[h] = tick[h];
                    cap[h] = tick[h] && rise;
                end
                rt_pkg::M_DUALCAP: begin
                    adv[h] = tick[h];
                    cap[h] = tick[h] && (rise || fall);
                end
                rt_pkg::M_GATED: begin
                    adv[h] = tick[h] && as;
                end
                rt_pkg::M_CAPCMP: begin
                    adv[h] = tick[h] && as;
                    cap[h] = tick[h] && fall;
                end
                rt_pkg::M_INGATED: begin
                    adv[h] = tick[h] && !as;
                end
                default: begin
                    adv[h] = 1'b0;
                end
            endcase
            // period ends on the following count clock
            endp[h] = adv[h] && view(cnt_q, h, casc)
                >= view(cmp_q, h, casc);
        end
    end

    // ------------------------------------------------------------
    // Counter, compare and capture storage.
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] v;
        v = '0;
        cnt_d = cnt_q;
        for (int h = 0; h < 2; h++) begin
            v = view(cnt_q, h, casc);
            if (adv[h]) begin
                if (!endp[h]) begin
                    v = v + rt_pkg::CNT_STEP;
                end else if (cfg_q[h].mode != rt_pkg::M_ONESHOT) begin
                    v = rt_pkg::CNT_RELOAD;
                end
                if (casc) begin
                    cnt_d = v;
                end else begin
                    cnt_d[h*rt_pkg::HALF_W +: rt_pkg::HALF_W] =
                        v[rt_pkg::HALF_W-1:0];
                end
            end
        end
        if (wr_cnt) begin
            cnt_d = BUS.wdata;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cnt_q <= rt_pkg::CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cmp_q <= '0;
            pwm_q <= '0;
        end else begin
            if (wr_cmp) begin
                cmp_q <= BUS.wdata;
            end
            if (wr_pwm) begin
                pwm_q <= BUS.wdata;
            end
            for (int h = 0; h < 2; h++) begin
                if (cap[h] && casc) begin
                    pwm_q <= cnt_q;
                end else if (cap[h]) begin
                    pwm_q[h*rt_pkg::HALF_W +: rt_pkg::HALF_W] <=
                        cnt_q[h*rt_pkg::HALF_W +: rt_pkg::HALF_W];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Output pins and interrupt flags.
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            out_q <= '0;
        end else begin
            for (int h = 0; h < 2; h++) begin
                if (endp[h] && cfg_q[h].mode == rt_pkg::M_COMPARE) begin
                    out_q[h] <= !out_q[h];
                end else if (adv[h] && cfg_q[h].mode == rt_pkg::M_PWM) begin
                    out_q[h] <= view(cnt_q, h, casc)
                        >= view(pwm_q, h, casc);
                end
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            irq_q <= '0;
            irq_out_q <= 1'b0;
        end else begin
            for (int h = 0; h < 2; h++) begin
                if (endp[h] || cap[h]) begin
                    irq_q[h] <= 1'b1;
                end else if (wr_fl && BUS.wdata[h]) begin
                    irq_q[h] <= 1'b0;
                end
            end
            irq_out_q <= (irq_q[0] && cfg_q[0].ie)
                || (irq_q[1] && cfg_q[1].ie);
        end
    end

    // ------------------------------------------------------------
    // Register read port.
    // ------------------------------------------------------------
    always_comb begin
        case (BUS.addr)
            rt_pkg::CNT_OFS: rd_d = cnt_q;
            rt_pkg::CMP_OFS: rd_d = cmp_q;
            rt_pkg::PWM_OFS: rd_d = pwm_q;
            rt_pkg::CTRL0_OFS: begin
                rd_d = {ctrl0_word(cfg_q[1], run_q[1]),
                    ctrl0_word(cfg_q[0], run_q[0])};
            end
            rt_pkg::CTRL1_OFS: begin
                rd_d = '0;
                for (int h = 0; h < 2; h++) begin
                    rd_d[h*rt_pkg::HALF_W + rt_pkg::SEL_LSB +: 2] =
                        cfg_q[h].sel;
                    rd_d[h*rt_pkg::HALF_W + rt_pkg::RDY_BIT] = rdy_q[h];
                end
                rd_d[rt_pkg::WID_LSB +: 2] = wid_q;
            end
            rt_pkg::INTFL_OFS: rd_d = {30'h0000_0000, irq_q};
            default: rd_d = '0;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= BUS.rd ? rd_d : '0;
        end
    end

    assign RDATA = rdata_q;
    assign PIN_OUT = out_q;
    assign IRQ = irq_out_q;

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    AST_RST_CNT: assert property ($fell(RST) |-> cnt_q == 32'h0000_0000)
        else $error("count not zero after reset");
    AST_CONT_RELOAD: assert property (endp[0] && !wr_cnt
        && cfg_q[0].mode == rt_pkg::M_CONT |=> cnt_q[15:0] == 16'h0001)
        else $error("continuous mode did not reload one");
    AST_ONESHOT_STOP: assert property (endp[0] && !wr_c0
        && cfg_q[0].mode == rt_pkg::M_ONESHOT
        |=> !cfg_q[0].en ##1 !run_q[0])
        else $error("one-shot did not stop");
    AST_IRQ_SET: assert property (endp[0] |=> irq_q[0])
        else $error("period end did not set flag");
    AST_LIVE_READ: assert property (BUS.rd
        && BUS.addr == rt_pkg::CNT_OFS |=> RDATA == $past(cnt_q))
        else $error("count read not live");
    AST_CMP_TOGGLE: assert property (endp[0]
        && cfg_q[0].mode == rt_pkg::M_COMPARE
        |=> PIN_OUT[0] != $past(out_q[0]))
        else $error("compare output did not toggle");
    AST_GATE_OFF: assert property (!cfg_q[0].en |=> !run_q[0])
        else $error("running status not cleared");
    AST_SEL_HOLD: assert property (cfg_q[0].clken |=> $stable(sel_q[0]))
        else $error("source changed with gate on");
    AST_CAPTURE: assert property (cap[0] && casc && !wr_pwm
        |=> pwm_q == $past(cnt_q))
        else $error("capture snapshot wrong");

    COV_CONT_END: cover property (endp[0] && cfg_q[0].mode == rt_pkg::M_CONT);
    COV_CAPTURE: cover property (cap[0]);
    COV_DUAL_END: cover property (endp[1]);
endmodule : rt_timer

// ===== rt_pkg.sv
package rt_pkg;
    // ------------------------------------------------------------
    // Register map and field layout.
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [4:0] CNT_OFS = 5'h00;
    localparam logic [4:0] CMP_OFS = 5'h04;
    localparam logic [4:0] PWM_OFS = 5'h08;
    localparam logic [4:0] CTRL0_OFS = 5'h0C;
    localparam logic [4:0] CTRL1_OFS = 5'h10;
    localparam logic [4:0] INTFL_OFS = 5'h14;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [31:0] CNT_RELOAD = 32'h0000_0001;
    localparam logic [31:0] CNT_STEP = 32'h0000_0001;
    localparam int HALF_W = 16;
    localparam int MODE_LSB = 0;
    localparam int PRES_LSB = 4;
    localparam int POL_BIT = 8;
    localparam int EN_BIT = 9;
    localparam int CLKEN_BIT = 10;
    localparam int IE_BIT = 11;
    localparam int SEL_LSB = 0;
    localparam int RDY_BIT = 2;
    localparam int WID_LSB = 14;
    localparam int PRE_W = 12;
    localparam logic [3:0] PRES_MAX = 4'hC;

    typedef enum logic [3:0] {
        M_ONESHOT = 4'h0,
        M_CONT = 4'h1,
        M_COUNTER = 4'h2,
        M_PWM = 4'h3,
        M_CAPTURE = 4'h4,
        M_COMPARE = 4'h5,
        M_GATED = 4'h6,
        M_CAPCMP = 4'h7,
        M_DUALCAP = 4'h8,
        M_INGATED = 4'hE
    } rt_mode_t;

    typedef enum logic [1:0] {
        W_CASCADE,
        W_SINGLE,
        W_DUAL,
        W_RSVD
    } rt_width_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rt_bus_t;

    typedef struct packed {
        rt_mode_t mode;
        logic [3:0] pres;
        logic pol;
        logic en;
        logic clken;
        logic ie;
        logic [1:0] sel;
    } rt_cfg_t;
endpackage : rt_pkg

// ===== rt_timer_test.sv
`timescale 1ns/1ps
module rt_timer_test;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    rt_pkg::rt_bus_t bus = '0;
    logic [31:0] rdata;
    logic [3:0] src_rdy = 4'h0;
    logic [3:0] src_tick = 4'hF;
    logic [1:0] pin_in = 2'h0;
    logic [1:0] pin_out;
    logic irq;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int k;
    int t;
    int pl[4] = '{0, 2, 5, 12};
    logic [31:0] d;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic po;
    logic wrapped;
    // Both halves gated on, and both halves gated on and enabled.
    localparam logic [31:0] GATE = 32'h0400_0400;
    localparam logic [31:0] RUN = 32'h0600_0600;

    always #4 CLOCK = ~CLOCK;

    rt_timer i_dut (
        .CLOCK(CLOCK),
        .RST(RST),
        .BUS(bus),
        .RDATA(rdata),
        .SRC_RDY(src_rdy),
        .SRC_TICK(src_tick),
        .PIN_IN(pin_in),
        .PIN_OUT(pin_out),
        .IRQ(irq)
    );

    // ------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------
    task automatic close_out();
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [4:0] ad, input logic [31:0] v);
        @(posedge CLOCK);
        bus.addr <= ad;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge CLOCK);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] ad, output logic [31:0] v);
        @(posedge CLOCK);
        bus.addr <= ad;
        bus.rd <= 1'b1;
        @(posedge CLOCK);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge CLOCK);
    endtask : cyc

    task automatic pin(input logic v, input int n);
        @(posedge CLOCK);
        pin_in[0] <= v;
        repeat (n - 1) @(posedge CLOCK);
    endtask : pin

    task automatic poll(input logic [4:0] ad, input int bn, input logic v);
        logic [31:0] x;
        x = '0;
        for (int i = 0; i < 40; i++) begin
            rd(ad, x);
            if (x[bn] === v) break;
        end
        check("poll", {31'h0, x[bn]}, {31'h0, v});
    endtask : poll

    // Count difference between two reads whose sampling edges are n apart.
    task automatic meas(input int n, output logic [31:0] df);
        logic [31:0] x0;
        logic [31:0] x1;
        rd(rt_pkg::CNT_OFS, x0);
        repeat (n - 2) @(posedge CLOCK);
        rd(rt_pkg::CNT_OFS, x1);
        df = x1 - x0;
    endtask : meas

    function automatic logic [15:0] h(logic [3:0] m, logic [3:0] p,
                                      logic ie);
        return (16'(m) << rt_pkg::MODE_LSB) | (16'(p) << rt_pkg::PRES_LSB)
            | (16'(ie) << rt_pkg::IE_BIT);
    endfunction : h

    task automatic start(input logic [31:0] cfg, input logic [31:0] c1,
                         input logic [31:0] cmp, input logic [31:0] cnt);
        wr(rt_pkg::CTRL0_OFS, 32'h0000_0000);
        poll(rt_pkg::CTRL0_OFS, rt_pkg::CLKEN_BIT, 1'b0);
        wr(rt_pkg::CTRL1_OFS, c1);
        wr(rt_pkg::CMP_OFS, cmp);
        wr(rt_pkg::CNT_OFS, cnt);
        wr(rt_pkg::INTFL_OFS, 32'h0000_0003);
        wr(rt_pkg::CTRL0_OFS, cfg | GATE);
        poll(rt_pkg::CTRL1_OFS, rt_pkg::RDY_BIT, 1'b1);
        wr(rt_pkg::CTRL0_OFS, cfg | RUN);
        poll(rt_pkg::CTRL0_OFS, rt_pkg::CLKEN_BIT, 1'b1);
    endtask : start

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h78ca));
        repeat (3) @(posedge CLOCK);
        RST <= 1'b0;
        rd(rt_pkg::CNT_OFS, d);
        check("cnt_reset", d, rt_pkg::CNT_RST);
        rd(5'h1C, d);
        check("unmapped", d, 32'h0000_0000);
        // Ready must wait for the chosen source to run.
        wr(rt_pkg::CTRL1_OFS, 32'h0000_0001);
        wr(rt_pkg::CTRL0_OFS, GATE);
        cyc(6);
        rd(rt_pkg::CTRL1_OFS, d);
        check("rdy_early", {31'h0, d[rt_pkg::RDY_BIT]}, 32'h0);
        @(posedge CLOCK);
        src_rdy <= 4'hF;
        poll(rt_pkg::CTRL1_OFS, rt_pkg::RDY_BIT, 1'b1);
        c = 32'(4 + $urandom_range(15));
        start({16'h0, h(rt_pkg::M_CONT, 4'h0, 1'b1)}, 0, c,
              rt_pkg::CNT_RELOAD);
        cyc(3 * c + 6);
        rd(rt_pkg::INTFL_OFS, d);
        check("flag", {31'h0, d[0]}, 32'h1);
        check("irq", {31'h0, irq}, 32'h1);
        wrapped = 1'b0;
        a = 32'h0;
        for (int i = 0; i < 2 * c; i++) begin
            rd(rt_pkg::CNT_OFS, d);
            check("cnt_range", {31'h0, d >= 1 && d <= c}, 32'h1);
            if (d < a) wrapped = 1'b1;
            a = d;
        end
        check("wrapped", {31'h0, wrapped}, 32'h1);
        start({16'h0, h(rt_pkg::M_CONT, 4'h0, 1'b0)}, 0, c, 32'h0);
        cyc(3 * c);
        rd(rt_pkg::INTFL_OFS, d);
        check("flag_masked", {31'h0, d[0]}, 32'h1);
        check("irq_masked", {31'h0, irq}, 32'h0);
        start({16'h0, h(rt_pkg::M_ONESHOT, 4'h0, 1'b1)}, 0, c, 32'h0);
        cyc(2 * c + 10);
        rd(rt_pkg::CNT_OFS, d);
        check("oneshot_cnt", d, c);
        rd(rt_pkg::CTRL0_OFS, d);
        check("oneshot_en", {31'h0, d[rt_pkg::EN_BIT]}, 32'h0);
        rd(rt_pkg::INTFL_OFS, d);
        check("oneshot_flag", {31'h0, d[0]}, 32'h1);
        foreach (pl[i]) begin
            k = (pl[i] == 12) ? 2 : 3 + $urandom_range(5);
            start({16'h0, h(rt_pkg::M_CONT, 4'(pl[i]), 1'b0)}, 0,
                  32'hFFFF_FFFF, 32'h0);
            meas(k << pl[i], d);
            check("prescale", d, 32'(k));
        end
        // Upper fields differ on purpose; they must not matter here.
        k = 20 + $urandom_range(40);
        start({h(rt_pkg::M_ONESHOT, 4'h7, 1'b0),
               h(rt_pkg::M_CONT, 4'h0, 1'b0)}, 0, 32'hFFFF_FFFF,
              32'h0000_FFF0);
        meas(k, d);
        check("cascade", d, 32'(k));
        start({h(rt_pkg::M_CONT, 4'h7, 1'b0),
               h(rt_pkg::M_CONT, 4'h0, 1'b0)}, 32'h0000_4000,
              32'h0000_FFFF, 32'h0);
        meas(16, d);
        check("single", d, 32'h0000_0010);
        start({h(rt_pkg::M_CONT, 4'h1, 1'b0),
               h(rt_pkg::M_CONT, 4'h0, 1'b0)}, 32'h0000_8000,
              32'hFFFF_FFFF, 32'h0);
        meas(32, d);
        check("dual_lo", {16'h0, d[15:0]}, 32'h0000_0020);
        check("dual_hi", {16'h0, d[31:16]}, 32'h0000_0010);
        start({16'h0, h(rt_pkg::M_COUNTER, 4'h0, 1'b0)}, 0,
              32'h0000_FFFF, 32'h0);
        rd(rt_pkg::CNT_OFS, a);
        t = 2 + $urandom_range(8);
        repeat (t) begin
            pin(1'b1, 4);
            pin(1'b0, 4);
        end
        rd(rt_pkg::CNT_OFS, b);
        check("counter", b - a, 32'(t));
        start({16'h0, h(rt_pkg::M_GATED, 4'h0, 1'b0)}, 0,
              32'h0000_FFFF, 32'h0);
        meas(20, d);
        check("gated_off", d, 32'h0);
        pin(1'b1, 4);
        meas(20, d);
        check("gated_on", d, 32'h0000_0014);
        pin(1'b0, 4);
        start({16'h0, h(rt_pkg::M_INGATED, 4'h0, 1'b0)}, 0,
              32'h0000_FFFF, 32'h0);
        meas(20, d);
        check("ingated", d, 32'h0000_0014);
        start({16'h0, h(rt_pkg::M_GATED, 4'h0, 1'b0)
               | 16'(1 << rt_pkg::POL_BIT)}, 0, 32'h0000_FFFF, 32'h0);
        meas(20, d);
        check("gated_pol", d, 32'h0000_0014);
        start({16'h0, h(rt_pkg::M_CAPTURE, 4'h0, 1'b0)}, 0,
              32'hFFFF_FFFF, 32'h0);
        cyc(10);
        rd(rt_pkg::CNT_OFS, a);
        pin(1'b1, 4);
        rd(rt_pkg::PWM_OFS, d);
        check("capture", {31'h0, d >= a && d <= a + 8}, 32'h1);
        pin(1'b0, 4);
        start({16'h0, h(rt_pkg::M_CAPCMP, 4'h0, 1'b0)}, 0,
              32'hFFFF_FFFF, 32'h0);
        pin(1'b1, 20);
        pin(1'b0, 6);
        rd(rt_pkg::PWM_OFS, d);
        check("capcmp", d, 32'h0000_0014);
        start({16'h0, h(rt_pkg::M_COMPARE, 4'h0, 1'b0)}, 0, c,
              rt_pkg::CNT_RELOAD);
        t = 0;
        po = pin_out[0];
        repeat (4 * c) begin
            @(posedge CLOCK);
            #1;
            if (pin_out[0] !== po) begin
                t++;
                po = pin_out[0];
            end
        end
        check("toggles", {31'h0, t >= 3 && t <= 5}, 32'h1);
        close_out();
    end
endmodule : rt_timer_test
